/* core/ata_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: Register index offsets on the internal 8-bit peripheral bus.
// Notes: Definitions only; included by bare name.
`ifndef ATA_PARAMS_SVH
`define ATA_PARAMS_SVH

// ----------------------------------------
// Register indices on the peripheral bus
// ----------------------------------------
`define ATA_OFS_CSR 4'h0
`define ATA_OFS_CTRL 4'h1
`define ATA_OFS_TSEL 4'h2
`define ATA_OFS_PMR 4'h3
`define ATA_OFS_MSTP_H 4'h4
`define ATA_OFS_MSTP_L 4'h5
`define ATA_OFS_SRES_H 4'h6
`define ATA_OFS_SRES_L 4'h7
`define ATA_OFS_HRES_H 4'h8
`define ATA_OFS_HRES_L 4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATA_CSR_SEND 7
`define ATA_CSR_HW_DONE 6
`define ATA_CSR_DONE_IE 5
`define ATA_CSR_SOFT_START 4
`define ATA_CSR_HW_START 3
`define ATA_CSR_BUSY 2
`define ATA_CSR_CANCEL 1
`define ATA_MSTP_STOP_BIT 2

// ----------------------------------------
// Reset values and fixed read bits
// ----------------------------------------
`define ATA_TSEL_RESET 8'hfc
`define ATA_TSEL_FIXED 6'h3f
`define ATA_TSEL_FIELD_RESET 2'h0
`define ATA_PMR_RESET 8'h00
`define ATA_MSTP_RESET 16'hffff
`define ATA_CSR_RESET 8'h01
`define ATA_UNMAPPED_READ 8'hff

// ----------------------------------------
// Timing: comparator settle time per SAR step
// ----------------------------------------
`define ATA_CLK_PERIOD_NS 8
`define ATA_SAR_SETTLE_NS 48
`define ATA_SAR_SETTLE_CYC ((`ATA_SAR_SETTLE_NS + `ATA_CLK_PERIOD_NS - 1) / `ATA_CLK_PERIOD_NS)

`endif

/* core/ata_pkg.sv */
// Purpose: Types shared by the converter control.
// Assumes: Widths fixed at the documented values.
// Notes: Holds types only; numbers live in the params header.
package ata_pkg;

  // Conversion owner; Gray steps idle -> soft -> hw.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SOFT = 2'h1,
    ST_HW = 2'h3
  } ata_mode_e;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    ata_mode_e mode;
    logic [1:0] tsel;
    logic [7:0] pmr;
    logic [15:0] mstp;
    logic [3:0] sch;
    logic [1:0] hch;
    logic done_ie;
    logic send;
    logic hw_done;
    logic busy;
    logic soft_cancel;
    logic send_seen;
    logic hw_done_seen;
    logic [9:0] sres;
    logic [9:0] hres;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic irq;
    logic [9:0] sar;
    logic [9:0] dac;
    logic [3:0] bitn;
    logic [3:0] settle;
    logic [2:0] ext_s;
    logic ext_lvl;
    logic [2:0] cmp_s;
    logic cmp_lvl;
    logic [3:0] chan;
  } ata_state_s;

endpackage

/* core/ata_ctrl.sv */
// Purpose: Trigger selection, arbitration and SAR sequencing of a 10-bit converter.
// Assumes: One 125 MHz clock; CPU on an 8-bit internal bus with one-cycle strobes.
// Notes: The analog comparator sits outside and answers on cmp_hi_in.
//
// How it works
// (RULE_01) Two-bit field picks the hardware start source.
// (RULE_02) Trigger select resets to fc, also in stop.
// (RULE_03) Top six trigger bits read one, unwritable.
// (RULE_04) Software changes source only while idle; the code accepts trigger select writes in any mode.
// (RULE_05) Port0 bits pick general or analog pin.
// (RULE_06) Stop bit halts converter; halt register resets ffff.
// (RULE_07) Upper result read latches lower byte.
// (RULE_08) Lower result read returns the latch.
// (RULE_09) CPU reads upper byte before lower byte.
// (RULE_10) Successive approximation gives ten-bit result.
// (RULE_11) Soft start flag starts, clears at end.
// (RULE_12) Soft field picks one of twelve inputs.
// (RULE_13) End sets soft or hw done flag.
// (RULE_14) Stop soft conversion before changing settings.
// (RULE_15) Stop hw conversion before changing settings.
// (RULE_16) Soft start during hw run sets busy.
// (RULE_17) Reading hw result clears busy.
// (RULE_18) Hw trigger cancels soft run, sets cancelled.
// (RULE_19) Fresh soft start clears the cancelled flag.
// (RULE_20) Trigger sets hw start flag until end.
// (RULE_21) Hw field picks one of four upper inputs.
// (RULE_22) Hw run swaps channel, then reverts.
// (RULE_23) Same-cycle requests: hardware wins.
// (RULE_24) Done flags clear by zero after read.
// (RULE_25) Writing hw flag zero aborts conversion.
// (RULE_26) Interrupt follows enable and done flags.
`timescale 1ns/1ps
`include "ata_params.svh"
`default_nettype none

module ata_ctrl (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] bus_addr_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic trigger_line_a_in,
  input wire logic internal_trigger_b_in,
  input wire logic ext_trigger_in,
  input wire logic cmp_hi_in,
  input wire logic low_power_in,
  output logic [7:0] bus_rdata_out,
  output logic conversion_end_irq_out,
  output logic [3:0] mux_channel_out,
  output logic [9:0] dac_code_out,
  output logic [7:0] pin_analog_select_out,
  output logic converter_stop_bit_out
);

  // ----------------------------------------
  // Constants and helpers
  // ----------------------------------------

  // Settle count per SAR step, loaded as a down counter.
  localparam logic [3:0] SETTLE_LOAD = 4'(`ATA_SAR_SETTLE_CYC - 1);

  // Reset image of the whole state word.
  localparam ata_pkg::ata_state_s RST_STATE = '{
    mode: ata_pkg::ST_IDLE,
    tsel: `ATA_TSEL_FIELD_RESET,
    pmr: `ATA_PMR_RESET,
    mstp: `ATA_MSTP_RESET,
    default: '0
  };

  // One-hot weight of a SAR bit position.
  function automatic logic [9:0] bit_weight(input logic [3:0] pos);
    bit_weight = 10'h001 << pos;
  endfunction

  // Upper byte of a left-justified ten-bit result.
  function automatic logic [7:0] res_hi(input logic [9:0] res);
    res_hi = res[9:2];
  endfunction

  // Lower byte of a left-justified ten-bit result.
  function automatic logic [7:0] res_lo(input logic [9:0] res);
    res_lo = {res[1:0], 6'h00};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------

  ata_pkg::ata_state_s st_r; // Current state word.
  ata_pkg::ata_state_s st_nxt; // Next state word.
  logic wr_csr; // Write strobe to the status register.
  logic soft_req; // Software asks for a conversion.
  logic ext_edge; // Filtered rising edge of the pin trigger.
  logic hw_trig; // Selected hardware trigger fired.
  logic cmp_now; // Filtered comparator level for this step.
  logic done; // Last SAR step finished this cycle.
  logic start_en; // A conversion starts this cycle.
  ata_pkg::ata_mode_e start_mode; // Owner of the starting conversion.
  logic [9:0] trial; // SAR code after the current decision.
  logic stop_all; // Module stop or low-power mode holds the block.

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // All behaviour is worked out here; writes come first so that
  // hardware events later in the process win over a same-cycle clear.
  always_comb begin
    st_nxt = st_r;
    ext_edge = 1'b0;
    hw_trig = 1'b0;
    done = 1'b0;
    start_en = 1'b0;
    start_mode = ata_pkg::ST_IDLE;
    trial = st_r.sar;
    cmp_now = st_r.cmp_lvl;
    wr_csr = bus_wr_in && (bus_addr_in == `ATA_OFS_CSR);
    soft_req = wr_csr && bus_wdata_in[`ATA_CSR_SOFT_START];
    // (RULE_06) Stop bit or sleep state
    stop_all = st_r.mstp[`ATA_MSTP_STOP_BIT] | low_power_in;

    // Three-stage filters; a level counts once stages two and three agree.
    st_nxt.ext_s = {st_r.ext_s[1:0], ext_trigger_in};
    st_nxt.cmp_s = {st_r.cmp_s[1:0], cmp_hi_in};
    if (st_r.ext_s[1] == st_r.ext_s[2]) begin
      st_nxt.ext_lvl = st_r.ext_s[2];
      ext_edge = st_r.ext_s[2] & ~st_r.ext_lvl;
    end
    if (st_r.cmp_s[1] == st_r.cmp_s[2]) begin
      st_nxt.cmp_lvl = st_r.cmp_s[2];
      cmp_now = st_r.cmp_s[2];
    end

    // (RULE_01) Start source decode
    case (st_r.tsel)
      2'h1: hw_trig = trigger_line_a_in;
      2'h2: hw_trig = internal_trigger_b_in;
      2'h3: hw_trig = ext_edge;
      default: hw_trig = 1'b0;
    endcase

    // Register reads; the answer is registered and stands until the next read.
    if (bus_rd_in) begin
      case (bus_addr_in)
        `ATA_OFS_CSR: begin
          st_nxt.rdata = {st_r.send, st_r.hw_done, st_r.done_ie, st_r.mode == ata_pkg::ST_SOFT,
                          st_r.mode == ata_pkg::ST_HW, st_r.busy, st_r.soft_cancel, 1'b1};
          // (RULE_24) Remember flags seen as one
          if (st_r.send) begin
            st_nxt.send_seen = 1'b1;
          end
          if (st_r.hw_done) begin
            st_nxt.hw_done_seen = 1'b1;
          end
        end
        `ATA_OFS_CTRL: st_nxt.rdata = {2'h0, st_r.hch, st_r.sch};
        // (RULE_03) Upper bits read as one
        `ATA_OFS_TSEL: st_nxt.rdata = {`ATA_TSEL_FIXED, st_r.tsel};
        `ATA_OFS_PMR: st_nxt.rdata = st_r.pmr;
        `ATA_OFS_MSTP_H: st_nxt.rdata = st_r.mstp[15:8];
        `ATA_OFS_MSTP_L: st_nxt.rdata = st_r.mstp[7:0];
        `ATA_OFS_SRES_H: begin
          // (RULE_07) Upper read fills the latch
          st_nxt.rdata = res_hi(st_r.sres);
          st_nxt.temp = res_lo(st_r.sres);
        end
        `ATA_OFS_HRES_H: begin
          st_nxt.rdata = res_hi(st_r.hres);
          st_nxt.temp = res_lo(st_r.hres);
          // (RULE_17) Result read clears busy
          st_nxt.busy = 1'b0;
        end
        `ATA_OFS_HRES_L: begin
          // (RULE_08) Lower read from latch
          st_nxt.rdata = st_r.temp;
          st_nxt.busy = 1'b0;
        end
        // (RULE_08) Lower read from latch
        `ATA_OFS_SRES_L: st_nxt.rdata = st_r.temp;
        default: st_nxt.rdata = `ATA_UNMAPPED_READ;
      endcase
    end

    // Register writes; result registers are read-only.
    if (bus_wr_in) begin
      case (bus_addr_in)
        `ATA_OFS_CSR: begin
          st_nxt.done_ie = bus_wdata_in[`ATA_CSR_DONE_IE];
          // (RULE_24) Clear only after seen
          if (!bus_wdata_in[`ATA_CSR_SEND] && st_r.send_seen) begin
            st_nxt.send = 1'b0;
            st_nxt.send_seen = 1'b0;
          end
          if (!bus_wdata_in[`ATA_CSR_HW_DONE] && st_r.hw_done_seen) begin
            st_nxt.hw_done = 1'b0;
            st_nxt.hw_done_seen = 1'b0;
          end
        end
        `ATA_OFS_CTRL: begin
          st_nxt.sch = bus_wdata_in[3:0];
          st_nxt.hch = bus_wdata_in[5:4];
        end
        // (RULE_03) Only the low field stores
        `ATA_OFS_TSEL: st_nxt.tsel = bus_wdata_in[1:0];
        // (RULE_05) Pin function bits
        `ATA_OFS_PMR: st_nxt.pmr = bus_wdata_in;
        `ATA_OFS_MSTP_H: st_nxt.mstp[15:8] = bus_wdata_in;
        `ATA_OFS_MSTP_L: st_nxt.mstp[7:0] = bus_wdata_in;
        default: st_nxt.mstp = st_r.mstp;
      endcase
    end

    // (RULE_10) One SAR decision per settle period, MSB first.
    if (st_r.mode != ata_pkg::ST_IDLE) begin
      if (st_r.settle != 4'h0) begin
        st_nxt.settle = st_r.settle - 4'h1;
      end else begin
        trial = cmp_now ? (st_r.sar | bit_weight(st_r.bitn)) : st_r.sar;
        st_nxt.sar = trial;
        if (st_r.bitn == 4'h0) begin
          done = 1'b1;
        end else begin
          st_nxt.bitn = st_r.bitn - 4'h1;
          st_nxt.settle = SETTLE_LOAD;
          st_nxt.dac = trial | bit_weight(st_r.bitn - 4'h1);
        end
      end
    end

    // (RULE_13) End of conversion sets done
    if (done) begin
      st_nxt.mode = ata_pkg::ST_IDLE;
      if (st_r.mode == ata_pkg::ST_SOFT) begin
        // (RULE_11) Soft flag drops at end
        st_nxt.sres = trial;
        st_nxt.send = 1'b1;
      end else begin
        // (RULE_20) Hw flag drops at end
        st_nxt.hres = trial;
        st_nxt.hw_done = 1'b1;
      end
    end

    // (RULE_14) Writing soft flag zero aborts
    if (wr_csr && !bus_wdata_in[`ATA_CSR_SOFT_START] && st_r.mode == ata_pkg::ST_SOFT) begin
      st_nxt.mode = ata_pkg::ST_IDLE;
    end
    // (RULE_25) Writing hw flag zero aborts
    if (wr_csr && !bus_wdata_in[`ATA_CSR_HW_START] && st_r.mode == ata_pkg::ST_HW) begin
      st_nxt.mode = ata_pkg::ST_IDLE;
    end

    // (RULE_23) Hardware checked before software
    if (hw_trig && st_r.mode != ata_pkg::ST_HW) begin
      // (RULE_18) Cancel a running soft conversion
      if (st_r.mode == ata_pkg::ST_SOFT && !done) begin
        st_nxt.soft_cancel = 1'b1;
      end
      if (soft_req) begin
        st_nxt.busy = 1'b1;
      end
      start_en = 1'b1;
      start_mode = ata_pkg::ST_HW;
    end else if (soft_req) begin
      if (st_r.mode == ata_pkg::ST_HW) begin
        // (RULE_16) Refused soft start marks busy
        st_nxt.busy = 1'b1;
      end else if (st_r.mode == ata_pkg::ST_IDLE || done) begin
        // (RULE_19) New soft start clears cancel
        st_nxt.soft_cancel = 1'b0;
        start_en = 1'b1;
        start_mode = ata_pkg::ST_SOFT;
      end
    end

    // (RULE_20) Start sets the owner flag
    if (start_en) begin
      st_nxt.mode = start_mode;
      st_nxt.sar = 10'h000;
      st_nxt.bitn = 4'h9;
      st_nxt.settle = SETTLE_LOAD;
      st_nxt.dac = bit_weight(4'h9);
    end

    // (RULE_02) Stop and sleep reinitialise
    if (stop_all) begin
      st_nxt.mode = ata_pkg::ST_IDLE;
      st_nxt.tsel = `ATA_TSEL_FIELD_RESET;
      st_nxt.done_ie = 1'b0;
      st_nxt.send = 1'b0;
      st_nxt.hw_done = 1'b0;
      st_nxt.busy = 1'b0;
      st_nxt.soft_cancel = 1'b0;
      st_nxt.send_seen = 1'b0;
      st_nxt.hw_done_seen = 1'b0;
    end

    // (RULE_22) Channel follows the owner
    if (st_nxt.mode == ata_pkg::ST_HW) begin
      // (RULE_21) Upper four inputs
      st_nxt.chan = {2'h2, st_nxt.hch};
    end else begin
      // (RULE_12) Soft channel field
      st_nxt.chan = st_nxt.sch;
    end

    // (RULE_26) Level interrupt request
    st_nxt.irq = st_nxt.done_ie & (st_nxt.send | st_nxt.hw_done);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // The whole state word is one register; reset loads constants only.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state word
  // ----------------------------------------

  assign bus_rdata_out = st_r.rdata;
  assign conversion_end_irq_out = st_r.irq;
  assign mux_channel_out = st_r.chan;
  assign dac_code_out = st_r.dac;
  assign pin_analog_select_out = st_r.pmr;
  assign converter_stop_bit_out = st_r.mstp[`ATA_MSTP_STOP_BIT];

endmodule

`default_nettype wire

/* tb/ata_afe_model.sv */
// Purpose: Analog front end model: a comparator against fixed channel levels.
// Assumes: Channel c sits at level {c, 6'h15}; the comparator answers at once.
// Notes: The block filters cmp_hi_in itself, so no delay is modelled here.
`timescale 1ns/1ps
`default_nettype none
module ata_afe_model (
  input wire logic [3:0] mux_channel_in,
  input wire logic [9:0] dac_code_in,
  output logic cmp_hi_out
);
  // High while the selected level is at or above the trial code.
  assign cmp_hi_out = ({mux_channel_in, 6'h15} >= dac_code_in);
endmodule
`default_nettype wire

/* tb/ata_ctrl_checker.sv */
// Purpose: Port-level checks of the converter control.
// Assumes: Read data is registered one cycle after the read strobe.
// Notes: Bound to every ata_ctrl instance.
`timescale 1ns/1ps
`include "ata_params.svh"
`default_nettype none
module ata_ctrl_checker (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] bus_addr_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic low_power_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic conversion_end_irq_out,
  input wire logic [7:0] pin_analog_select_out,
  input wire logic converter_stop_bit_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_RDATA_STANDS: assert property (!bus_rd_in |=> $stable(bus_rdata_out))
    else $error("read data moved without a read");
  AST_TSEL_FIXED: assert property ((bus_rd_in && bus_addr_in == `ATA_OFS_TSEL)
    |=> bus_rdata_out[7:2] == 6'h3f) else $error("trigger select upper bits not one");
  AST_LO_PAD: assert property ((bus_rd_in && (bus_addr_in == `ATA_OFS_SRES_L
    || bus_addr_in == `ATA_OFS_HRES_L)) |=> bus_rdata_out[5:0] == 6'h00)
    else $error("low result byte has stray bits");
  AST_LP_TSEL: assert property ((low_power_in ##1 (low_power_in && bus_rd_in
    && bus_addr_in == `ATA_OFS_TSEL)) |=> bus_rdata_out == 8'hfc)
    else $error("trigger select not reset in low power");
  AST_PIN_WR: assert property ((bus_wr_in && bus_addr_in == `ATA_OFS_PMR)
    |=> pin_analog_select_out == $past(bus_wdata_in)) else $error("pin mode write lost");
  AST_PIN_HOLD: assert property (!(bus_wr_in && bus_addr_in == `ATA_OFS_PMR)
    |=> $stable(pin_analog_select_out)) else $error("pin mode changed without write");
  AST_STOP_WR: assert property ((bus_wr_in && bus_addr_in == `ATA_OFS_MSTP_L)
    |=> converter_stop_bit_out == $past(bus_wdata_in[2])) else $error("stop bit write lost");
  AST_STOP_IRQ: assert property (converter_stop_bit_out [*3] |-> !conversion_end_irq_out)
    else $error("interrupt raised while stopped");
  AST_RST_OUT: assert property ($rose(rst_b_in) |-> bus_rdata_out == 8'h00
    && pin_analog_select_out == 8'h00 && converter_stop_bit_out && !conversion_end_irq_out)
    else $error("outputs not at reset values");
  cover property ($rose(conversion_end_irq_out));
  cover property (bus_rd_in && bus_addr_in == `ATA_OFS_HRES_H);
  cover property (low_power_in ##1 (low_power_in && bus_rd_in));
endmodule
bind ata_ctrl ata_ctrl_checker ata_ctrl_checker_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .bus_addr_in(bus_addr_in), .bus_rd_in(bus_rd_in), .bus_wr_in(bus_wr_in),
  .bus_wdata_in(bus_wdata_in), .low_power_in(low_power_in), .bus_rdata_out(bus_rdata_out),
  .conversion_end_irq_out(conversion_end_irq_out),
  .pin_analog_select_out(pin_analog_select_out), .converter_stop_bit_out(converter_stop_bit_out));
`default_nettype wire

/* tb/adc_trigger_arbitration_ctrl_test.sv */
// Purpose: Self-checking bench of the converter control.
// Assumes: Inputs change on the falling edge; the analog model gives channel levels.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
`include "ata_params.svh"
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module adc_trigger_arbitration_ctrl_test;
  logic clk, rst_b, rd, wr, ta, tb2, te, lp, cmp, irq, stp;
  logic [3:0] a, mux;
  logic [7:0] wd, rdo, pins, v;
  logic [9:0] dac, r;
  int fails, tests_run;
  ata_ctrl ata_ctrl_inst (.mclk_in(clk), .rst_b_in(rst_b), .bus_addr_in(a), .bus_rd_in(rd),
    .bus_wr_in(wr), .bus_wdata_in(wd), .trigger_line_a_in(ta), .internal_trigger_b_in(tb2),
    .ext_trigger_in(te), .cmp_hi_in(cmp), .low_power_in(lp), .bus_rdata_out(rdo),
    .conversion_end_irq_out(irq), .mux_channel_out(mux), .dac_code_out(dac),
    .pin_analog_select_out(pins), .converter_stop_bit_out(stp));
  ata_afe_model ata_afe_model_inst (.mux_channel_in(mux), .dac_code_in(dac), .cmp_hi_out(cmp));
  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // One write strobe, held for exactly one sampling edge.
  task automatic wrr(input logic [3:0] ad, input logic [7:0] d);
    @(negedge clk);
    a = ad;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // One read; the answer is registered at the strobe edge.
  task automatic rdr(input logic [3:0] ad, output logic [7:0] d);
    @(negedge clk);
    a = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdo;
  endtask
  // Polls the status register until a flag rises, bounded well past 60 cycles.
  task automatic poll(input int b);
    v = 8'h00;
    for (int i = 0; i < 40 && v[b] !== 1'b1; i++) rdr(`ATA_OFS_CSR, v);
    `CHK("done flag", 1'b1, v[b])
  endtask
  // Fires one trigger source; the pin one is long enough to pass the filter.
  task automatic pulse(input int p);
    @(negedge clk);
    ta = (p == 1);
    tb2 = (p == 2);
    te = (p == 3);
    @(negedge clk);
    ta = 1'b0;
    tb2 = 1'b0;
    repeat (6) @(negedge clk);
    te = 1'b0;
  endtask
  // Level of channel c as the analog model holds it.
  function automatic logic [9:0] lvl(input logic [3:0] c);
    return {c, 6'h15};
  endfunction
  // Reset values, stop gating, trigger field, pin mode and low-power reinitialisation.
  task automatic t_reset();
    logic [3:0] ix[5] = '{`ATA_OFS_TSEL, `ATA_OFS_PMR, `ATA_OFS_MSTP_H, `ATA_OFS_MSTP_L, 4'hf};
    logic [7:0] ex[5] = '{8'hfc, 8'h00, 8'hff, 8'hff, 8'hff};
    rdr(`ATA_OFS_CSR, v);
    `CHK("csr reset", 8'h01, v)
    foreach (ix[i]) begin
      rdr(ix[i], v);
      `CHK("reg reset", ex[i], v)
    end
    `CHK("stop out", 1'b1, stp)
    wrr(`ATA_OFS_TSEL, 8'h03);
    rdr(`ATA_OFS_TSEL, v);
    `CHK("tsel in stop", 8'hfc, v)
    wrr(`ATA_OFS_MSTP_L, 8'hfb);
    `CHK("stop cleared", 1'b0, stp)
    wrr(`ATA_OFS_MSTP_H, 8'h7f);
    rdr(`ATA_OFS_MSTP_H, v);
    `CHK("halt hi", 8'h7f, v)
    wrr(`ATA_OFS_TSEL, 8'h02);
    rdr(`ATA_OFS_TSEL, v);
    `CHK("tsel field", 8'hfe, v)
    wrr(`ATA_OFS_PMR, 8'h5a);
    rdr(`ATA_OFS_PMR, v);
    `CHK("pmr", 8'h5a, v)
    `CHK("pins", 8'h5a, pins)
    @(negedge clk);
    lp = 1'b1;
    rdr(`ATA_OFS_TSEL, v);
    lp = 1'b0;
    `CHK("tsel low power", 8'hfc, v)
    $display("t_reset finished");
  endtask
  // One software run end to end, then the read-before-clear rule on the done flag.
  task automatic t_soft();
    wrr(`ATA_OFS_CTRL, 8'h23);
    rdr(`ATA_OFS_CTRL, v);
    `CHK("ctrl", 8'h23, v)
    wrr(`ATA_OFS_CSR, 8'h30);
    `CHK("soft mux", 4'h3, mux)
    `CHK("first trial", 10'h200, dac)
    rdr(`ATA_OFS_CSR, v);
    `CHK("sst running", 1'b1, v[4])
    poll(7);
    `CHK("sst end", 1'b0, v[4])
    `CHK("irq", 1'b1, irq)
    r = lvl(4'h3);
    rdr(`ATA_OFS_SRES_H, v);
    `CHK("soft hi", r[9:2], v)
    rdr(`ATA_OFS_SRES_L, v);
    `CHK("soft lo", {r[1:0], 6'h00}, v)
    wrr(`ATA_OFS_CSR, 8'h20);
    rdr(`ATA_OFS_CSR, v);
    `CHK("send cleared", 8'h21, v)
    `CHK("irq off", 1'b0, irq)
    wrr(`ATA_OFS_CSR, 8'h30);
    repeat (70) @(negedge clk);
    wrr(`ATA_OFS_CSR, 8'h20);
    rdr(`ATA_OFS_CSR, v);
    `CHK("clear unread", 1'b1, v[7])
    wrr(`ATA_OFS_CSR, 8'h20);
    rdr(`ATA_OFS_CSR, v);
    `CHK("clear read", 1'b0, v[7])
    $display("t_soft finished");
  endtask
  // A hardware trigger cancels a software run; a refused soft start marks busy.
  task automatic t_preempt();
    wrr(`ATA_OFS_TSEL, 8'h01);
    wrr(`ATA_OFS_CSR, 8'h30);
    repeat (10) @(negedge clk);
    pulse(1);
    rdr(`ATA_OFS_CSR, v);
    `CHK("cancel", 8'h0a, v & 8'h1a)
    `CHK("hw mux", 4'ha, mux)
    wrr(`ATA_OFS_CSR, 8'h38);
    rdr(`ATA_OFS_CSR, v);
    `CHK("busy", 8'h0c, v & 8'h1c)
    poll(6);
    `CHK("hw end", 8'h02, v & 8'h9a)
    `CHK("mux back", 4'h3, mux)
    `CHK("hw irq", 1'b1, irq)
    r = lvl(4'ha);
    rdr(`ATA_OFS_HRES_H, v);
    `CHK("hw hi", r[9:2], v)
    rdr(`ATA_OFS_HRES_L, v);
    `CHK("hw lo", {r[1:0], 6'h00}, v)
    rdr(`ATA_OFS_CSR, v);
    `CHK("busy gone", 1'b0, v[2])
    wrr(`ATA_OFS_CSR, 8'h10);
    rdr(`ATA_OFS_CSR, v);
    `CHK("soft_cancelled_flag gone", 1'b0, v[1])
    wrr(`ATA_OFS_CSR, 8'h00);
    rdr(`ATA_OFS_CSR, v);
    `CHK("soft abort", 1'b0, v[4])
    $display("t_preempt finished");
  endtask
  // Every source setting against every trigger line; only the chosen one starts.
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      wrr(`ATA_OFS_TSEL, 8'(s));
      for (int p = 1; p < 4; p++) begin
        pulse(p);
        rdr(`ATA_OFS_CSR, v);
        `CHK("source", 1'(s == p), v[3])
        if (v[3] === 1'b1) begin
          wrr(`ATA_OFS_CSR, 8'h00);
          rdr(`ATA_OFS_CSR, v);
          `CHK("hw abort", 8'h00, v & 8'h48)
        end
      end
    end
    $display("t_sources finished");
  endtask
  // Software and hardware requests in one cycle; hardware must win.
  task automatic t_same();
    wrr(`ATA_OFS_TSEL, 8'h01);
    @(negedge clk);
    a = `ATA_OFS_CSR;
    wd = 8'h10;
    wr = 1'b1;
    ta = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    ta = 1'b0;
    rdr(`ATA_OFS_CSR, v);
    `CHK("hw wins", 8'h0c, v & 8'h1c)
    wrr(`ATA_OFS_CSR, 8'h00);
    rdr(`ATA_OFS_HRES_H, v);
    $display("t_same finished");
  endtask
  // Stop while the interrupt stands and a fresh run is going; all must fall back.
  task automatic t_stop();
    wrr(`ATA_OFS_CSR, 8'h30);
    repeat (70) @(negedge clk);
    `CHK("irq before stop", 1'b1, irq)
    wrr(`ATA_OFS_CSR, 8'h30);
    wrr(`ATA_OFS_MSTP_L, 8'hff);
    `CHK("stop set", 1'b1, stp)
    rdr(`ATA_OFS_CSR, v);
    `CHK("csr stopped", 8'h01, v)
    rdr(`ATA_OFS_TSEL, v);
    `CHK("tsel stopped", 8'hfc, v)
    `CHK("irq stopped", 1'b0, irq)
    $display("t_stop finished");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: reset for four cycles, then the scenarios in turn.
  initial begin
    {rd, wr, ta, tb2, te, lp} = '0;
    a = 4'h0;
    wd = 8'h00;
    rst_b = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_soft();
    t_preempt();
    t_sources();
    t_same();
    t_stop();
    finish_test();
  end
  // Watchdog: the scenarios need under a thousand cycles; this allows twenty thousand.
  initial begin
    #160000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
